/* File: logic/fps_pkg.sv */
// package: constants for the front panel status and indicator control block
package fps_pkg;
  // =====================================
  // clock and timing
  localparam int unsigned FPS_CLK_HZ = 20000000;
  localparam int unsigned FPS_LAMP_MS = 62;
  localparam int unsigned FPS_LAMP_CYCLES = (FPS_CLK_HZ / 1000) * FPS_LAMP_MS;
  // =====================================
  // address groups (high nibble of the peripheral address)
  localparam logic [3:0] FPS_STATUS_GROUP = 4'h0;
  localparam logic [3:0] FPS_CONTROL_GROUP = 4'h3;
  // =====================================
  // control register fields
  localparam int unsigned FPS_CTL_INTERROGATION_INDICATOR_BIT = 0;
  localparam int unsigned FPS_CTL_REPLY_BIT = 1;
  localparam int unsigned FPS_CTL_OSC_BIT = 2;
  localparam int unsigned FPS_CTL_DSPRST_BIT = 3;
  localparam logic [3:0] FPS_CTL_RESET = 4'h3;
  // =====================================
  // status buffer fields
  localparam int unsigned FPS_ST_INTERROGATION_INDICATOR_BIT = 0;
  localparam int unsigned FPS_ST_REPLY_BIT = 1;
  localparam int unsigned FPS_ST_EOC_BIT = 2;
  localparam int unsigned FPS_ST_DSPRDY_BIT = 3;
  localparam int unsigned FPS_ST_MONITOR_BIT = 4;
  localparam int unsigned FPS_ST_MAINS_BIT = 5;
  localparam int unsigned FPS_ST_BATT_BIT = 6;
  localparam int unsigned FPS_ST_OSC_BIT = 7;
endpackage

/* File: logic/fps_lamp_timer.sv */
// one retriggerable lamp one-shot timer
`timescale 1ns/1ps
module fps_lamp_timer
  import fps_pkg::*;
#(
  parameter int unsigned LAMP_CYCLES = FPS_LAMP_CYCLES
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // trigger and lamp
  input wire logic trigger_in,
  output logic lamp_on_out
);
  localparam int unsigned CW = $clog2(LAMP_CYCLES + 1);

  logic [CW-1:0] count_reg;

  // =====================================
  // counter: a new trigger reloads the full period
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      count_reg <= '0;
    else if (trigger_in)
      count_reg <= CW'(LAMP_CYCLES);
    else if (count_reg != '0)
      count_reg <= count_reg - 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      lamp_on_out <= 1'b0;
    else
      lamp_on_out <= trigger_in || (count_reg > CW'(1));
  end
endmodule

/* File: logic/fps_panel_ctl.sv */
// front panel status buffer, indicator control register and shared memory access
`timescale 1ns/1ps
// Operation
// - status bit 4 reads 1 when the monitor jumper is absent
// - status bit 5 reads 0 with mains present, 1 when absent
// - status bit 6 reads 0 at low battery, 1 when charged
// - status bit 7 shows the oscillator shutdown output
// - control register selected by select 4 with address group 3
// - bits 0 and 1: write 0 arms, then 1 lights the indicator
// - control bit 2 drives the oscillator shutdown line
// - control bit 3 holds the signal processor board in reset
// - at reset bits 0 and 1 are 1, both indicators off
// - a rising indicator bit lights its lamp for about 62 ms
// - shared memory is reached only while memory select 0 is asserted
// - transceiver direction goes high during a shared memory access
// - read strobe low to read, write strobe low to write
// - status buffer read with select 0 and address group 0
// - status bits 0 and 1 show the present indicator outputs
module fps_panel_ctl
  import fps_pkg::*;
#(
  parameter int unsigned LAMP_CYCLES = FPS_LAMP_CYCLES
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // processor bus, selects active low
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic periph_select_0_n_in,
  input wire logic periph_select_4_n_in,
  input wire logic memory_select_0_n_in,
  output logic [7:0] rdata_out,
  output logic rdata_oe_n_out,
  // monitored board signals
  input wire logic conv_done_in,
  input wire logic dsp_ready_in,
  input wire logic monitor_jumper_absent_in,
  input wire logic mains_absent_in,
  input wire logic battery_level_flag_in,
  // controlled outputs
  output logic interrogation_indicator_out,
  output logic reply_indicator_out,
  output logic osc_shutdown_ctl_out,
  output logic dsp_reset_out,
  // shared memory access
  output logic xcvr_dir_out,
  output logic mem_read_strobe_n_out,
  output logic mem_write_strobe_n_out
);
  logic [3:0] ctl_reg;
  logic [1:0] lamp_trig_reg;
  logic interrogation_indicator_lamp;
  logic reply_lamp;
  logic status_rd;
  logic control_wr;
  logic mem_sel;
  logic mem_rd;
  logic mem_wr;
  logic [7:0] status_word;

  // =====================================
  // decode helpers
  // one select, one address group and one strobe, all seen on the same edge
  function automatic logic periph_hit(
    input logic select_n,
    input logic [3:0] group,
    input logic [3:0] want,
    input logic strobe_n
  );
    periph_hit = !select_n && (group == want) && !strobe_n;
  endfunction

  // bits that go from 0 to 1 between the stored and the written value
  function automatic logic [1:0] rise_bits(
    input logic [1:0] old_bits,
    input logic [1:0] new_bits
  );
    rise_bits = new_bits & ~old_bits;
  endfunction

  // =====================================
  // address decode
  assign status_rd = periph_hit(periph_select_0_n_in, addr_in[7:4], FPS_STATUS_GROUP, rd_n_in);
  assign control_wr = periph_hit(periph_select_4_n_in, addr_in[7:4], FPS_CONTROL_GROUP, wr_n_in);
  assign mem_sel = !memory_select_0_n_in;
  // write gives way when both strobes are low, so the transceiver never fights a read
  assign mem_rd = mem_sel && !rd_n_in;
  assign mem_wr = mem_sel && !wr_n_in && rd_n_in;

  // =====================================
  // control register; upper data bits never stored
  // a strobe held over two edges stores the same value twice, harmless
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      ctl_reg <= FPS_CTL_RESET;
    else if (control_wr)
      ctl_reg <= wdata_in[3:0];
  end

  // =====================================
  // one-shot triggers
  // rising edge of a stored indicator bit fires its one-shot
  // a 1 written over a stored 1 is no edge, so a held strobe fires once
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      lamp_trig_reg <= 2'h0;
    else if (control_wr)
      lamp_trig_reg <= rise_bits(ctl_reg[1:0], wdata_in[1:0]);
    else
      lamp_trig_reg <= 2'h0;
  end

  // =====================================
  // one-shot timers, one per indicator so each keeps its own period
  fps_lamp_timer #(
    .LAMP_CYCLES(LAMP_CYCLES)
  ) u_interrogation_indicator_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .trigger_in(lamp_trig_reg[FPS_CTL_INTERROGATION_INDICATOR_BIT]),
    .lamp_on_out(interrogation_indicator_lamp)
  );

  fps_lamp_timer #(
    .LAMP_CYCLES(LAMP_CYCLES)
  ) u_reply_timer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .trigger_in(lamp_trig_reg[FPS_CTL_REPLY_BIT]),
    .lamp_on_out(reply_lamp)
  );

  // =====================================
  // controlled outputs
  // lamps pass one more flop so every output leaves a register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      interrogation_indicator_out <= 1'b0;
      reply_indicator_out <= 1'b0;
    end
    else
    begin
      interrogation_indicator_out <= interrogation_indicator_lamp;
      reply_indicator_out <= reply_lamp;
    end
  end

  // oscillator and board reset follow the stored bits one clock later
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      osc_shutdown_ctl_out <= 1'b0;
      dsp_reset_out <= 1'b0;
    end
    else
    begin
      osc_shutdown_ctl_out <= ctl_reg[FPS_CTL_OSC_BIT];
      dsp_reset_out <= ctl_reg[FPS_CTL_DSPRST_BIT];
    end
  end

  // =====================================
  // status buffer
  always_comb
  begin
    status_word = 8'h00;
    // conversion and processor-ready bits pass straight through
    status_word[FPS_ST_INTERROGATION_INDICATOR_BIT] = interrogation_indicator_out;
    status_word[FPS_ST_REPLY_BIT] = reply_indicator_out;
    status_word[FPS_ST_EOC_BIT] = conv_done_in;
    status_word[FPS_ST_DSPRDY_BIT] = dsp_ready_in;
    status_word[FPS_ST_MONITOR_BIT] = monitor_jumper_absent_in;
    status_word[FPS_ST_MAINS_BIT] = mains_absent_in;
    status_word[FPS_ST_BATT_BIT] = battery_level_flag_in;
    status_word[FPS_ST_OSC_BIT] = osc_shutdown_ctl_out;
  end

  // data appears one clock after the read is seen
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rdata_out <= 8'h00;
      rdata_oe_n_out <= 1'b1;
    end
    else
    begin
      rdata_out <= status_rd ? status_word : 8'h00;
      rdata_oe_n_out <= !status_rd;
    end
  end

  // =====================================
  // shared memory strobes, only inside a memory select cycle
  // registered, so the strobes trail the processor strobes by one clock
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      xcvr_dir_out <= 1'b0;
      mem_read_strobe_n_out <= 1'b1;
      mem_write_strobe_n_out <= 1'b1;
    end
    else
    begin
      xcvr_dir_out <= mem_rd || mem_wr;
      mem_read_strobe_n_out <= !mem_rd;
      mem_write_strobe_n_out <= !mem_wr;
    end
  end
endmodule

/* File: tb/fps_panel_monitor.sv */
// checker: port assertions for the panel control block
`timescale 1ns/1ps
module fps_panel_monitor (
  // watched ports
  input wire logic clk_in, rst_in, rd_n_in, wr_n_in,
  input wire logic periph_select_0_n_in, periph_select_4_n_in, memory_select_0_n_in,
  input wire logic [7:0] addr_in, wdata_in, rdata_out,
  input wire logic rdata_oe_n_out, monitor_jumper_absent_in, mains_absent_in, battery_level_flag_in,
  input wire logic interrogation_indicator_out, reply_indicator_out, osc_shutdown_ctl_out, dsp_reset_out,
  input wire logic xcvr_dir_out, mem_read_strobe_n_out, mem_write_strobe_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire ctl_wr = !periph_select_4_n_in && addr_in[7:4] == 4'h3 && !wr_n_in;
  wire st_rd = !periph_select_0_n_in && addr_in[7:4] == 4'h0 && !rd_n_in;
  wire mem_on = !memory_select_0_n_in;
  // ==========
  // status and control
  AST_ST_BITS: assert property (!rdata_oe_n_out |-> rdata_out[6:4] ==
    $past({battery_level_flag_in, mains_absent_in, monitor_jumper_absent_in})) else $error("status bits");
  AST_ST_RD: assert property (st_rd |=> !rdata_oe_n_out) else $error("read not answered");
  AST_NO_RD: assert property (!st_rd |=> rdata_oe_n_out && rdata_out == 8'h00) else $error("stray read");
  AST_OSC: assert property (ctl_wr |-> ##2 osc_shutdown_ctl_out == $past(wdata_in[2], 2))
    else $error("osc line");
  AST_DSP: assert property (ctl_wr |-> ##2 dsp_reset_out == $past(wdata_in[3], 2)) else $error("dsp reset");
  AST_ST_LIVE: assert property (!rdata_oe_n_out |->
    rdata_out[7] == $past(osc_shutdown_ctl_out) &&
    rdata_out[1:0] == $past({reply_indicator_out, interrogation_indicator_out})) else $error("live status bits");
  AST_INTERROGATION_INDICATOR_SRC: assert property ($rose(interrogation_indicator_out) |->
    $past(ctl_wr, 3) && $past(wdata_in[0], 3)) else $error("interrogation lamp without write");
  AST_REPLY_SRC: assert property ($rose(reply_indicator_out) |->
    $past(ctl_wr, 3) && $past(wdata_in[1], 3)) else $error("reply lamp without write");
  // ==========
  // shared memory
  AST_MEM_IDLE: assert property (!mem_on |=> mem_read_strobe_n_out && mem_write_strobe_n_out && !xcvr_dir_out)
    else $error("strobe without select");
  AST_MEM_RD: assert property (mem_on && !rd_n_in |=> !mem_read_strobe_n_out && xcvr_dir_out)
    else $error("memory read");
  AST_MEM_WR: assert property (mem_on && !wr_n_in && rd_n_in |=> !mem_write_strobe_n_out)
    else $error("memory write");
  cover property (ctl_wr);
  cover property ($rose(interrogation_indicator_out));
  cover property (mem_on && !wr_n_in);
  cover property (st_rd);
endmodule
bind fps_panel_ctl fps_panel_monitor u_fps_panel_monitor (.clk_in(clk_in), .rst_in(rst_in),
  .rd_n_in(rd_n_in), .wr_n_in(wr_n_in), .periph_select_0_n_in(periph_select_0_n_in),
  .periph_select_4_n_in(periph_select_4_n_in), .memory_select_0_n_in(memory_select_0_n_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out), .rdata_oe_n_out(rdata_oe_n_out),
  .monitor_jumper_absent_in(monitor_jumper_absent_in), .mains_absent_in(mains_absent_in),
  .battery_level_flag_in(battery_level_flag_in), .interrogation_indicator_out(interrogation_indicator_out),
  .reply_indicator_out(reply_indicator_out), .osc_shutdown_ctl_out(osc_shutdown_ctl_out),
  .dsp_reset_out(dsp_reset_out), .xcvr_dir_out(xcvr_dir_out), .mem_read_strobe_n_out(mem_read_strobe_n_out),
  .mem_write_strobe_n_out(mem_write_strobe_n_out));

/* File: tb/fps_cpu_model.sv */
// processor partner: one-cycle bus requests
`timescale 1ns/1ps
module fps_cpu_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out = 8'hFF,
  output logic [7:0] wdata_out = 8'hFF,
  output logic rd_n_out = 1'b1,
  output logic wr_n_out = 1'b1,
  output logic [2:0] sel_n_out = 3'h7
);
  task automatic cyc(input logic [2:0] s, input logic wr, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge clk_in);
    sel_n_out = s;
    rd_n_out = wr;
    wr_n_out = !wr;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_in);
    q = rdata_in;
    sel_n_out = 3'h7;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    // released lines invert so a stale value never looks valid
    addr_out = ~a;
    wdata_out = ~d;
  endtask
endmodule

/* File: tb/fps_panel_ctl_tb.sv */
// testbench for the front panel status and indicator control block
`timescale 1ns/1ps
module fps_panel_ctl_tb;
  typedef struct {logic [4:0] st; logic [7:0] d; logic [7:0] exp;} fps_row_t;
  localparam int LC = 20;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] st = 5'h00;
  logic [7:0] addr, wdata, rdata, q;
  logic [2:0] sel_n;
  logic rd_n, wr_n, oe_n, lamp0, lamp1, osc, dsp, xdir, mrd_n, mwr_n;
  wire [1:0] lamps = {lamp1, lamp0};
  int n_fail = 0;
  int checked = 0;
  int k;
  fps_row_t rows [4] = '{'{5'h1F, 8'hF7, 8'hFC}, '{5'h00, 8'h0B, 8'h00}, '{5'h0A, 8'h07, 8'hA8},
    '{5'h15, 8'h03, 8'h54}};
  initial forever #25 clk_in = ~clk_in;
  fps_cpu_model u_fps_cpu_model (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .sel_n_out(sel_n));
  fps_panel_ctl #(.LAMP_CYCLES(LC)) u_fps_panel_ctl (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
    .wdata_in(wdata), .rd_n_in(rd_n), .wr_n_in(wr_n), .periph_select_0_n_in(sel_n[2]),
    .periph_select_4_n_in(sel_n[1]), .memory_select_0_n_in(sel_n[0]), .rdata_out(rdata), .rdata_oe_n_out(oe_n),
    .conv_done_in(st[0]), .dsp_ready_in(st[1]), .monitor_jumper_absent_in(st[2]), .mains_absent_in(st[3]),
    .battery_level_flag_in(st[4]), .interrogation_indicator_out(lamp0), .reply_indicator_out(lamp1),
    .osc_shutdown_ctl_out(osc), .dsp_reset_out(dsp), .xcvr_dir_out(xdir), .mem_read_strobe_n_out(mrd_n),
    .mem_write_strobe_n_out(mwr_n));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_lamp(input int b, input logic v);
    for (k = 0; k < 40 && lamps[b] !== v; k++) @(negedge clk_in);
    if (k == 40)
    begin
      n_fail++;
      tally_and_finish;
    end
  endtask
  // ==========
  // main sequence
  initial
  begin
    repeat (16) @(negedge clk_in);
    rst_in = 1'b0;
    chk("reset outputs", 8'h08, {lamp1, lamp0, osc, dsp, oe_n, 3'h0});
    foreach (rows[i])
    begin
      st = rows[i].st;
      u_fps_cpu_model.cyc(3'b101, 1'b1, 8'h30, rows[i].d, q);
      u_fps_cpu_model.cyc(3'b011, 1'b0, 8'h05, 8'h00, q);
      chk("status", rows[i].exp, q);
      chk("osc dsp", {6'h00, rows[i].d[3:2]}, {6'h00, dsp, osc});
    end
    u_fps_cpu_model.cyc(3'b101, 1'b1, 8'h23, 8'h0C, q);
    u_fps_cpu_model.cyc(3'b011, 1'b1, 8'h30, 8'h0C, q);
    u_fps_cpu_model.cyc(3'b011, 1'b0, 8'h30, 8'h00, q);
    chk("wrong group read", 8'h00, q);
    chk("refused writes", 8'h00, {6'h00, dsp, osc});
    $display("test registers done");
    for (int b = 0; b < 2; b++)
    begin
      u_fps_cpu_model.cyc(3'b101, 1'b1, 8'h30, 8'h03 ^ (8'h01 << b), q);
      u_fps_cpu_model.cyc(3'b101, 1'b1, 8'h30, 8'h03, q);
      wait_lamp(b, 1'b1);
      u_fps_cpu_model.cyc(3'b011, 1'b0, 8'h00, 8'h00, q);
      chk("lamp status", 8'h01 << b, q & 8'h03);
      for (k = 0; k < 60 && lamps[b] === 1'b1; k++) @(negedge clk_in);
      chk("lamp on time", 8'(LC), 8'(k + 2));
    end
    u_fps_cpu_model.cyc(3'b101, 1'b1, 8'h30, 8'h02, q);
    u_fps_cpu_model.cyc(3'b101, 1'b1, 8'h30, 8'h03, q);
    wait_lamp(0, 1'b1);
    repeat (LC - 6) @(negedge clk_in);
    u_fps_cpu_model.cyc(3'b101, 1'b1, 8'h30, 8'h02, q);
    u_fps_cpu_model.cyc(3'b101, 1'b1, 8'h30, 8'h03, q);
    repeat (4) @(negedge clk_in);
    chk("retriggered lamp", 8'h01, {7'h00, lamp0});
    wait_lamp(0, 1'b0);
    $display("test lamps done");
    u_fps_cpu_model.cyc(3'b101, 1'b1, 8'h30, 8'h0C, q);
    repeat (2) @(negedge clk_in);
    chk("before reset", 8'h03, {6'h00, dsp, osc});
    rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    chk("mid-run reset", 8'h08, {lamp1, lamp0, osc, dsp, oe_n, 3'h0});
    u_fps_cpu_model.cyc(3'b101, 1'b1, 8'h30, 8'h03, q);
    repeat (4) @(negedge clk_in);
    chk("no lamp after reset", 8'h00, {6'h00, lamps});
    $display("test mid-run reset done");
    u_fps_cpu_model.cyc(3'b110, 1'b0, 8'h00, 8'h00, q);
    chk("memory read strobes", 8'h05, {5'h00, xdir, mrd_n, mwr_n});
    chk("memory read data", 8'h00, q);
    u_fps_cpu_model.cyc(3'b110, 1'b1, 8'h00, 8'h55, q);
    chk("memory write strobes", 8'h06, {5'h00, xdir, mrd_n, mwr_n});
    u_fps_cpu_model.cyc(3'b111, 1'b0, 8'h00, 8'h00, q);
    chk("no memory select", 8'h03, {5'h00, xdir, mrd_n, mwr_n});
    chk("unselected read", 8'h00, q);
    $display("test memory done");
    tally_and_finish;
  end
endmodule
